// *** design/adcss_pkg.sv ***
package adcss_pkg;
    // clock and timebase
    localparam int CLK_HZ = 100_000_000;
    localparam int TIMEBASE_HZ = 1_000_000;
    localparam int TICK_DIV = CLK_HZ / TIMEBASE_HZ;
    // longest wait from conversion start to stored result
    localparam int CONV_LIMIT_US = 20;
    localparam int CONV_LIMIT_CYC = CONV_LIMIT_US * (CLK_HZ / 1_000_000);

    localparam int INTERVAL_W = 16;
    localparam logic [15:0] INTERVAL_MIN = 16'h0002;
    localparam logic [15:0] INTERVAL_RST = 16'h0064;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTERVAL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0C;
    localparam logic [7:0] ADDR_CNT1_LOAD = 8'h10;
    localparam logic [7:0] ADDR_CNT2_LOAD = 8'h14;
    localparam logic [7:0] ADDR_CNT_VALUE = 8'h18;
    localparam logic [7:0] ADDR_CNT_CTRL = 8'h1C;

    // control register fields
    localparam int CTRL_ACQ = 0;
    localparam int CTRL_SCAN = 1;
    localparam int CTRL_DIFF = 2;
    localparam int CTRL_EXT = 3;
    localparam int CTRL_TIMER = 4;
    localparam int CTRL_CHAN_LO = 5;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // status register fields
    localparam int STAT_NOT_EMPTY = 0;
    localparam int STAT_OVERFLOW = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_TIMEOUT = 3;
    localparam int STAT_LEVEL_LO = 4;

    // counter control fields
    localparam int CCTL_EN1 = 0;
    localparam int CCTL_EN2 = 1;
    localparam int CCTL_EDGE2 = 2;
    localparam logic [2:0] CCTL_RST = 3'h0;
    localparam logic [15:0] CNT_LOAD_RST = 16'hFFFF;

    typedef enum logic [0:0] {CS_IDLE, CS_WAIT} adcss_conv_e;
endpackage : adcss_pkg

// *** design/adcss_sequencer.sv ***
`timescale 1ns/1ps
// Function
// - rising timer or external edge starts conversion
// - 16-bit interval counter on 1 MHz tick
// - zero reached: pulse and reload, repeat
// - each result stored in 512x16 FIFO
// - converter restarts without waiting for reads
// - conversion into full FIFO flags overflow
// - status shows FIFO holds data
// - results are two's complement 16-bit
// - single channel held for whole acquisition
// - scan steps down to zero, then wraps
// - scan length two to eight channels
// - eight single inputs or four differential pairs
// - interval counter and counter 1 gates enabled
// - interval counter hidden; counters 1, 2 exposed
// - undriven counter gate and clock read high
// - gate and output timed on counter clock rise
// - external start stored within 20 us
module adcss_sequencer #(
    parameter int FIFO_DEPTH = 512,
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_convert_n,
    output logic adcStart,
    input wire logic adcDone,
    input wire logic [DATA_W-1:0] adcResult,
    output logic [2:0] muxChannel,
    output logic muxDiff,
    input wire logic counter1_clock_in,
    output logic counter1_out,
    input wire logic counter2_gate_in,
    input wire logic counter2_clock_in,
    output logic counter2_out
);
    import adcss_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);

    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
        $error("FIFO_DEPTH must be a power of two");
    end
    if (DATA_W > 16 || PTR_W + 1 > 12) begin : g_chk2
        $error("DATA_W or FIFO_DEPTH too large for register layout");
    end

    // highest usable channel; scan needs at least two channels
    function automatic logic [2:0] chanLimit(input logic [2:0] c,
                                             input logic diff,
                                             input logic scan);
        logic [2:0] r;
        r = diff ? {1'b0, c[1:0]} : c;
        if (scan && r == 3'h0) begin
            r = 3'h1;
        end
        return r;
    endfunction : chanLimit

    // bus decode
    logic setupPhase;
    logic accessWr;
    logic accessRd;
    logic addrOk;
    assign setupPhase = psel && !penable;
    assign accessWr = psel && penable && pwrite;
    assign accessRd = psel && penable && !pwrite;
    assign addrOk = (paddr[1:0] == 2'h0) && (paddr <= ADDR_CNT_CTRL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrOk;

    logic [CTRL_W-1:0] ctrl;
    logic [15:0] interval;
    logic [2:0] cntCtrl;
    logic [15:0] cntLoad [2];
    logic ctrlWr;
    logic intervalWr;
    assign ctrlWr = accessWr && paddr == ADDR_CTRL;
    assign intervalWr = accessWr && paddr == ADDR_INTERVAL;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            interval <= INTERVAL_RST;
            cntCtrl <= CCTL_RST;
            cntLoad[0] <= CNT_LOAD_RST;
            cntLoad[1] <= CNT_LOAD_RST;
        end else if (accessWr) begin
            case (paddr)
                ADDR_CTRL: ctrl <= pwdata[CTRL_W-1:0];
                ADDR_INTERVAL: interval <= (pwdata[15:0] < INTERVAL_MIN) ?
                    INTERVAL_MIN : pwdata[15:0];
                ADDR_CNT1_LOAD: cntLoad[0] <= pwdata[15:0];
                ADDR_CNT2_LOAD: cntLoad[1] <= pwdata[15:0];
                ADDR_CNT_CTRL: cntCtrl <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    logic acqOn;
    logic scanOn;
    logic diffOn;
    logic [2:0] chanTop;
    assign acqOn = ctrl[CTRL_ACQ];
    assign scanOn = ctrl[CTRL_SCAN];
    assign diffOn = ctrl[CTRL_DIFF];
    assign chanTop = chanLimit(ctrl[CTRL_CHAN_LO +: 3], diffOn, scanOn);

    // pin synchronisers; reset high, as pulled-up pins idle high
    localparam int NPIN = 4;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta;
    logic [NPIN-1:0] pinSync;
    logic [NPIN-1:0] pinPrev;
    assign pinRaw = {counter2_gate_in, counter2_clock_in,
                     counter1_clock_in, ext_convert_n};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= '1;
            pinSync <= '1;
            pinPrev <= '1;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end
    logic extRise;
    assign extRise = pinSync[0] && !pinPrev[0];

    // 1 MHz timebase enable
    logic [$clog2(TICK_DIV)-1:0] divCnt;
    logic tickEn;
    assign tickEn = divCnt == '0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= '0;
        end else if (tickEn) begin
            divCnt <= ($clog2(TICK_DIV))'(TICK_DIV - 1);
        end else begin
            divCnt <= divCnt - 1'b1;
        end
    end

    // sample-interval counter, internal only
    logic [INTERVAL_W-1:0] timerCnt;
    logic [INTERVAL_W-1:0] reloadVal;
    logic sampleTickOut;
    logic tickPrev;
    logic timerRise;
    assign reloadVal = interval - 1'b1;
    assign timerRise = sampleTickOut && !tickPrev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timerCnt <= '0;
            sampleTickOut <= 1'b0;
        end else if (!ctrl[CTRL_TIMER] || intervalWr) begin
            timerCnt <= reloadVal;
            sampleTickOut <= 1'b0;
        end else if (tickEn) begin
            // gate permanently enabled: only software's enable stops it
            if (timerCnt == '0) begin
                timerCnt <= reloadVal;
                sampleTickOut <= 1'b1;
            end else begin
                timerCnt <= timerCnt - 1'b1;
                sampleTickOut <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickPrev <= 1'b0;
        end else begin
            tickPrev <= sampleTickOut;
        end
    end

    logic trigger;
    assign trigger = acqOn && (timerRise || (ctrl[CTRL_EXT] && extRise));

    // conversion sequencing
    adcss_conv_e convState;
    logic [$clog2(CONV_LIMIT_CYC+1)-1:0] convTimer;
    logic convTimeout;
    logic storeNow;
    logic timeoutFlag;
    assign convTimeout = convState == CS_WAIT &&
        convTimer == ($clog2(CONV_LIMIT_CYC+1))'(CONV_LIMIT_CYC);
    assign storeNow = convState == CS_WAIT && adcDone;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convState <= CS_IDLE;
            adcStart <= 1'b0;
            convTimer <= '0;
        end else begin
            adcStart <= 1'b0;
            case (convState)
                CS_IDLE: begin
                    convTimer <= '0;
                    if (trigger) begin
                        adcStart <= 1'b1;
                        convState <= CS_WAIT;
                    end
                end
                CS_WAIT: begin
                    // new triggers fall through here unused
                    convTimer <= convTimer + 1'b1;
                    if (storeNow || convTimeout) begin
                        convState <= CS_IDLE;
                    end
                end
                default: convState <= CS_IDLE;
            endcase
        end
    end

    // channel sequencing
    logic [2:0] curChan;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            curChan <= '0;
        end else if (ctrlWr) begin
            curChan <= chanLimit(pwdata[CTRL_CHAN_LO +: 3],
                                 pwdata[CTRL_DIFF], pwdata[CTRL_SCAN]);
        end else if (storeNow && scanOn) begin
            curChan <= (curChan == '0) ? chanTop : curChan - 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            muxChannel <= '0;
            muxDiff <= 1'b0;
        end else begin
            // in differential mode chan c pairs with c+4
            muxChannel <= diffOn ? {1'b0, curChan[1:0]} : curChan;
            muxDiff <= diffOn;
        end
    end

    // result FIFO; raw two's complement words kept as delivered
    logic [DATA_W-1:0] fifoMem [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] level;
    logic fifoFull;
    logic popNow;
    logic pushNow;
    logic overflow;
    assign fifoFull = level == (PTR_W+1)'(FIFO_DEPTH);
    assign pushNow = storeNow && !fifoFull;
    assign popNow = accessRd && paddr == ADDR_RESULT && level != '0;
    always_ff @(posedge clk) begin
        if (pushNow) begin
            fifoMem[wrPtr] <= adcResult;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else begin
            if (pushNow) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (popNow) begin
                rdPtr <= rdPtr + 1'b1;
            end
            case ({pushNow, popNow})
                2'b10: level <= level + 1'b1;
                2'b01: level <= level - 1'b1;
                default: ;
            endcase
        end
    end

    // sticky flags: a new event beats a clear in the same cycle
    logic statusWr;
    assign statusWr = accessWr && paddr == ADDR_STATUS;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow <= 1'b0;
        end else if (storeNow && fifoFull) begin
            overflow <= 1'b1;
        end else if (statusWr && pwdata[STAT_OVERFLOW]) begin
            overflow <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeoutFlag <= 1'b0;
        end else if (convTimeout) begin
            timeoutFlag <= 1'b1;
        end else if (statusWr && pwdata[STAT_TIMEOUT]) begin
            timeoutFlag <= 1'b0;
        end
    end

    // general-purpose counters, timed on their own clock rise
    logic [15:0] cntVal [2];
    logic [1:0] cntOut;
    logic [1:0] cntRise;
    logic [1:0] cntGate;
    logic [1:0] gatePrev;
    logic [1:0] started;
    logic [1:0] cntLoadWr;
    assign cntGate = {pinSync[3], 1'b1};
    assign cntLoadWr = {accessWr && paddr == ADDR_CNT2_LOAD,
                        accessWr && paddr == ADDR_CNT1_LOAD};
    for (genvar i = 0; i < 2; i++) begin : g_cnt
        logic edgeMode;
        logic countOk;
        assign cntRise[i] = pinSync[i+1] && !pinPrev[i+1];
        assign edgeMode = (i == 1) && cntCtrl[CCTL_EDGE2];
        assign countOk = cntCtrl[i] && (edgeMode ? started[i] : cntGate[i]);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cntVal[i] <= CNT_LOAD_RST;
                cntOut[i] <= 1'b0;
                gatePrev[i] <= 1'b1;
                started[i] <= 1'b0;
            end else if (cntLoadWr[i]) begin
                cntVal[i] <= pwdata[15:0];
                cntOut[i] <= 1'b0;
                started[i] <= 1'b0;
            end else if (cntRise[i]) begin
                gatePrev[i] <= cntGate[i];
                if (cntGate[i] && !gatePrev[i]) begin
                    started[i] <= 1'b1;
                end
                if (countOk) begin
                    if (cntVal[i] == '0) begin
                        cntVal[i] <= cntLoad[i];
                        cntOut[i] <= !cntOut[i];
                    end else begin
                        cntVal[i] <= cntVal[i] - 1'b1;
                    end
                end
            end
        end
    end
    assign counter1_out = cntOut[0];
    assign counter2_out = cntOut[1];

    // read data is latched in the setup cycle so it leaves a flip-flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (setupPhase && !pwrite) begin
            prdata <= '0;
            case (paddr)
                ADDR_CTRL: prdata[CTRL_W-1:0] <= ctrl;
                ADDR_INTERVAL: prdata[15:0] <= interval;
                ADDR_STATUS: begin
                    prdata[STAT_NOT_EMPTY] <= level != '0;
                    prdata[STAT_OVERFLOW] <= overflow;
                    prdata[STAT_BUSY] <= convState == CS_WAIT;
                    prdata[STAT_TIMEOUT] <= timeoutFlag;
                    prdata[STAT_LEVEL_LO +: PTR_W+1] <= level;
                end
                ADDR_RESULT: prdata[DATA_W-1:0] <= fifoMem[rdPtr];
                ADDR_CNT1_LOAD: prdata[15:0] <= cntLoad[0];
                ADDR_CNT2_LOAD: prdata[15:0] <= cntLoad[1];
                ADDR_CNT_VALUE: prdata <= {cntVal[1], cntVal[0]};
                ADDR_CNT_CTRL: prdata[2:0] <= cntCtrl;
                default: ;
            endcase
        end
    end

    // checks
    property p_startOnTrigger;
        @(posedge clk) disable iff (!rst_n)
        (trigger && convState == CS_IDLE) |=> adcStart ##1 !adcStart;
    endproperty
    a_startOnTrigger: assert property (p_startOnTrigger)
        else $error("trigger did not start one conversion");

    property p_tickSpacing;
        @(posedge clk) disable iff (!rst_n)
        tickEn |=> !tickEn [*8];
    endproperty
    a_tickSpacing: assert property (p_tickSpacing)
        else $error("timebase enable too frequent");

    property p_reload;
        @(posedge clk) disable iff (!rst_n)
        (ctrl[CTRL_TIMER] && !intervalWr && tickEn && timerCnt == '0)
        |=> sampleTickOut && timerCnt == $past(reloadVal);
    endproperty
    a_reload: assert property (p_reload)
        else $error("interval counter did not pulse and reload");

    property p_push;
        @(posedge clk) disable iff (!rst_n)
        (storeNow && !fifoFull && !popNow) |=> level == $past(level) + 1'b1;
    endproperty
    a_push: assert property (p_push)
        else $error("result not stored");

    property p_overflow;
        @(posedge clk) disable iff (!rst_n)
        (storeNow && fifoFull && !popNow) |=> overflow && $stable(level);
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not flagged or data written");

    property p_readyAgain;
        @(posedge clk) disable iff (!rst_n)
        storeNow |=> convState == CS_IDLE;
    endproperty
    a_readyAgain: assert property (p_readyAgain)
        else $error("converter not free after store");

    property p_holdChan;
        @(posedge clk) disable iff (!rst_n)
        (acqOn && !scanOn && !ctrlWr) |=> $stable(curChan);
    endproperty
    a_holdChan: assert property (p_holdChan)
        else $error("channel moved in single-channel mode");

    property p_scanWrap;
        @(posedge clk) disable iff (!rst_n)
        (storeNow && scanOn && !ctrlWr && curChan == '0)
        |=> curChan == $past(chanTop) && curChan != '0;
    endproperty
    a_scanWrap: assert property (p_scanWrap)
        else $error("scan did not wrap to highest channel");

    property p_diffPair;
        @(posedge clk) disable iff (!rst_n)
        muxDiff |-> muxChannel[2] == 1'b0;
    endproperty
    a_diffPair: assert property (p_diffPair)
        else $error("differential select outside pairs");

    property p_ignoreBusy;
        @(posedge clk) disable iff (!rst_n)
        (convState == CS_WAIT && trigger && !storeNow && !convTimeout)
        |=> !adcStart && convState == CS_WAIT;
    endproperty
    a_ignoreBusy: assert property (p_ignoreBusy)
        else $error("trigger disturbed running conversion");

    // age of the running conversion; bound too long to unroll as a delay
    logic [$clog2(CONV_LIMIT_CYC+2)-1:0] convAge;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convAge <= '0;
        end else if (convState == CS_IDLE) begin
            convAge <= '0;
        end else begin
            convAge <= convAge + 1'b1;
        end
    end
    property p_convBound;
        @(posedge clk) disable iff (!rst_n)
        convState == CS_WAIT |-> convAge <= CONV_LIMIT_CYC;
    endproperty
    a_convBound: assert property (p_convBound)
        else $error("conversion exceeded limit");

    property p_cnt1Gate;
        @(posedge clk) disable iff (!rst_n)
        (cntCtrl[CCTL_EN1] && cntRise[0] && !cntLoadWr[0] && cntVal[0] != '0)
        |=> cntVal[0] == $past(cntVal[0]) - 1'b1;
    endproperty
    a_cnt1Gate: assert property (p_cnt1Gate)
        else $error("counter 1 failed to count with gate tied");
endmodule : adcss_sequencer

// *** test/adcss_adc_model.sv ***
`timescale 1ns/1ps
module adcss_adc_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic adcStart,
    input wire logic [7:0] latency,
    output logic adcDone,
    output logic [15:0] adcResult
);
    logic busy;
    logic [7:0] waitCnt;
    logic [15:0] seqVal;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            waitCnt <= 8'h00;
            adcDone <= 1'b0;
            adcResult <= 16'h0000;
            seqVal <= 16'h7FFE;
        end else begin
            adcDone <= 1'b0;
            // data only valid with done; wander otherwise
            adcResult <= ~adcResult;
            if (adcStart) begin
                busy <= 1'b1;
                waitCnt <= latency;
            end else if (busy && waitCnt == 8'h00) begin
                busy <= 1'b0;
                adcDone <= 1'b1;
                // codes cross the sign boundary early
                adcResult <= seqVal;
                seqVal <= seqVal + 16'h0001;
            end else if (busy) begin
                waitCnt <= waitCnt - 8'h01;
            end
        end
    end
endmodule : adcss_adc_model

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
    import adcss_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, latency;
    logic [31:0] pwdata, prdata, r;
    logic extN, adcStart, adcDone, muxDiff;
    logic c1Clk, c1Out, c2Gate, c2Clk, c2Out;
    logic [15:0] adcResult, resExp;
    logic [2:0] muxChannel;
    logic [3:0] chanQ[$];
    int stT[$];
    int cyc, starts, dones, doneT, checked, miscompares;
    adcss_sequencer adcss_sequencer_inst (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_convert_n(extN), .adcStart(adcStart),
        .adcDone(adcDone), .adcResult(adcResult),
        .muxChannel(muxChannel), .muxDiff(muxDiff),
        .counter1_clock_in(c1Clk), .counter1_out(c1Out),
        .counter2_gate_in(c2Gate), .counter2_clock_in(c2Clk),
        .counter2_out(c2Out));
    adcss_adc_model adcss_adc_model_inst (.clk(clk), .rst_n(rst_n),
        .adcStart(adcStart), .latency(latency), .adcDone(adcDone),
        .adcResult(adcResult));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic waitv(ref int v, input int t);
        int n;
        n = 0;
        while (v < t && n < 5000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(v), 32'(t));
    endtask : waitv
    // pins idle high, as the pull-ups leave them; m = {c2Clk,c1Clk,extN}
    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            {c2Clk, c1Clk, extN} <= {c2Clk, c1Clk, extN} & ~m;
            repeat (4) @(posedge clk);
            {c2Clk, c1Clk, extN} <= {c2Clk, c1Clk, extN} | m;
            repeat (6) @(posedge clk);
        end
    endtask : pulse
    task automatic drain(input int n);
        repeat (n) begin
            apb(1'b0, ADDR_RESULT, 32'h0);
            chk(r, {16'h0000, resExp});
            resExp++;
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[0], 1'b0);
    endtask : drain
    task automatic regs;
        apb(1'b0, ADDR_INTERVAL, 32'h0);
        chk(r, 32'h0000_0064);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        apb(1'b1, ADDR_INTERVAL, 32'h1);
        apb(1'b0, ADDR_INTERVAL, 32'h0);
        chk(r, 32'(INTERVAL_MIN));
    endtask : regs
    // e4 is {diff, channel} for single runs, highest channel for scans
    task automatic run(input logic [7:0] ctl, input int n,
                       input logic [3:0] e4);
        int s;
        int d;
        int p;
        logic [3:0] x;
        p = INTERVAL_MIN * TICK_DIV;
        chanQ.delete();
        stT.delete();
        s = starts;
        apb(1'b1, ADDR_CTRL, {24'h0, ctl});
        waitv(starts, s + n);
        apb(1'b1, ADDR_CTRL, 32'h0);
        waitv(dones, starts);
        for (int i = 0; i < n; i++) begin
            x = ctl[CTRL_SCAN] ? 4'(e4 - i % (e4 + 1)) : e4;
            chk(chanQ[i], x);
            if (i > 0) begin
                d = stT[i] - stT[i-1];
                chk(d, p);
            end
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[0], 1'b1);
        drain(starts - s);
    endtask : run
    task automatic ext_trig;
        int s, t0;
        s = starts;
        latency <= 8'h3C;
        pulse(3'b001, 1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0009);
        t0 = cyc;
        // second edge lands mid-conversion
        pulse(3'b001, 2);
        waitv(dones, s + 1);
        chk(32'(doneT - t0 <= CONV_LIMIT_CYC), 32'h1);
        chk(32'(starts), 32'(s + 1));
        drain(1);
    endtask : ext_trig
    task automatic overflow;
        latency <= 8'h00;
        pulse(3'b001, 512);
        waitv(dones, starts);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[13:0], 14'h2001);
        pulse(3'b001, 1);
        waitv(dones, starts);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[13:0], 14'h2003);
        apb(1'b1, ADDR_STATUS, 32'h0000_0002);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[1:0], 2'h1);
        drain(512);
        resExp++;
    endtask : overflow
    task automatic counters;
        apb(1'b1, ADDR_CNT1_LOAD, 32'h3);
        apb(1'b1, ADDR_CNT2_LOAD, 32'h5);
        apb(1'b1, ADDR_CNT_CTRL, 32'h3);
        c2Gate <= 1'b0;
        pulse(3'b110, 2);
        apb(1'b0, ADDR_CNT_VALUE, 32'h0);
        chk(r, 32'h0005_0001);
        c2Gate <= 1'b1;
        pulse(3'b110, 3);
        apb(1'b0, ADDR_CNT_VALUE, 32'h0);
        chk(r[31:16], 16'h0002);
        chk(c1Out, 1'b1);
        apb(1'b1, ADDR_CNT_CTRL, 32'h6);
        c2Gate <= 1'b0;
        apb(1'b1, ADDR_CNT2_LOAD, 32'hA);
        pulse(3'b100, 2);
        c2Gate <= 1'b1;
        pulse(3'b100, 2);
        apb(1'b0, ADDR_CNT_VALUE, 32'h0);
        chk(r[31:16], 16'h0009);
    endtask : counters
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    always @(negedge clk) begin
        cyc++;
        if (adcStart === 1'b1) begin
            starts++;
            chanQ.push_back({muxDiff, muxChannel});
            stT.push_back(cyc);
        end
        if (adcDone === 1'b1) begin
            dones++;
            doneT = cyc;
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {extN, c1Clk, c2Clk, c2Gate} = 4'hF;
        latency = 8'h05;
        resExp = 16'h7FFE;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        regs();
        run(8'hB1, 3, 4'h5);
        run(8'h33, 3, 4'h1);
        run(8'hF3, 9, 4'h7);
        run(8'hD5, 2, 4'hA);
        ext_trig();
        overflow();
        counters();
        close_out();
    end
endmodule : tb
